/* File: hdl/bsl_core.sv */
// branch, skip, compare, copy and load executor of the 8-bit core
//
// Chosen here: the placing of the registers and the plain strobed port.
module bsl_core
    import bsl_pkg::*;
#(
    parameter int          ADDR_W   = ADDR_W_DEF,
    parameter logic [15:0] SP_RESET = SP_RESET_DEF
)
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    output logic      [ADDR_W-1:0] pm_addr,
    input  wire logic [15:0]       pm_rdata,
    output logic      [15:0]       ds_addr,
    input  wire logic [7:0]        ds_rdata,
    output logic                   ds_rd,
    output logic                   ds_we,
    output logic      [7:0]        ds_wdata,
    output logic      [IO_AW-1:0]  io_addr,
    input  wire logic [7:0]        io_rdata,
    output logic                   io_rd,
    output logic      [ADDR_W-1:0] pc,
    output logic      [7:0]        status_flag_register
);

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        ST_FETCH, ST_EXEC, ST_SKIPCHK, ST_IOWAIT, ST_WORD2, ST_PUSH_HI,
        ST_PREDEC, ST_LOADWB, ST_POP_HI, ST_POP_LO
    } bsl_state_t;

    bsl_state_t        state_reg, state_next;
    logic [ADDR_W-1:0] pc_reg, pc_next;
    logic [ADDR_W-1:0] pm_addr_reg, pm_addr_next;
    logic [15:0]       sp_reg, sp_next;
    logic [7:0]        status_flag_register_reg, status_flag_register_next;
    logic [15:0]       ir_reg, ir_next;
    logic [15:0]       tmp_reg, tmp_next;
    logic [15:0]       ds_addr_reg, ds_addr_next;
    logic [7:0]        ds_wdata_reg, ds_wdata_next;
    logic              ds_rd_reg, ds_rd_next;
    logic              ds_we_reg, ds_we_next;
    logic [IO_AW-1:0]  io_addr_reg, io_addr_next;
    logic              io_rd_reg, io_rd_next;

    logic [7:0]        gpr [NUM_REGS];
    logic              we0, we1;
    logic [4:0]        wi0, wi1;
    logic [7:0]        wd0, wd1;

    logic [15:0]       w;
    logic [7:0]        rd_v, rr_v, rd_hi_v;
    logic [15:0]       xptr, yptr, ptr;
    logic [ADDR_W-1:0] ret_addr;
    logic              is_cpi, is_cpc;
    logic [7:0]        cmp_a, cmp_b;
    logic [5:0]        cmp_flags;
    logic              br_taken;
    logic [ADDR_W-1:0] br_target;

    assign w        = pm_rdata;
    assign rd_v     = gpr[f_rd(w)];
    assign rr_v     = gpr[f_rr(w)];
    assign rd_hi_v  = gpr[f_rd_hi(w)];
    assign xptr     = {gpr[X_HI], gpr[X_LO]};
    assign yptr     = {gpr[Y_HI], gpr[Y_LO]};
    // bit 2 of the pointer opcodes tells the X forms from the Y forms
    assign ptr      = w[2] ? xptr : yptr;
    assign ret_addr = pc_reg + ADDR_W'(STEP_TWO);
    assign is_cpi   = op_is(w, M_4, P_CPI);
    assign is_cpc   = op_is(w, M_6, P_CPC);
    assign cmp_a    = is_cpi ? rd_hi_v : rd_v;
    assign cmp_b    = is_cpi ? f_imm(w) : rr_v;

    ////////////////////////////////////////////////////////////////////////////////
    bsl_cmp u_cmp (
        .op_a      (cmp_a),
        .op_b      (cmp_b),
        .use_carry (is_cpc),
        .status_flag_register      (status_flag_register_reg),
        .flags     (cmp_flags)
    );

    bsl_branch #(
        .ADDR_W (ADDR_W)
    ) u_branch (
        .status_flag_register     (status_flag_register_reg),
        .sel      (f_bit(w)),
        .want_set (~w[10]),
        .offs     (f_offs(w)),
        .pc       (pc_reg),
        .taken    (br_taken),
        .target   (br_target)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next    = state_reg;
        pc_next       = pc_reg;
        pm_addr_next  = pm_addr_reg;
        sp_next       = sp_reg;
        status_flag_register_next     = status_flag_register_reg;
        ir_next       = ir_reg;
        tmp_next      = tmp_reg;
        ds_addr_next  = ds_addr_reg;
        ds_wdata_next = ds_wdata_reg;
        ds_rd_next    = 1'b0;
        ds_we_next    = 1'b0;
        io_addr_next  = io_addr_reg;
        io_rd_next    = 1'b0;
        we0           = 1'b0;
        we1           = 1'b0;
        wi0           = 5'h00;
        wi1           = 5'h00;
        wd0           = 8'h00;
        wd1           = 8'h00;

        unique case (state_reg)
            ST_FETCH: begin
                pm_addr_next = pc_reg;
                state_next   = ST_EXEC;
            end

            ST_EXEC: begin
                ir_next    = w;
                pc_next    = pc_reg + ADDR_W'(STEP_ONE);
                state_next = ST_FETCH;
                if (op_is(w, M_6, P_COMPARE_SKIP_EQUAL)) begin
                    if (rd_v == rr_v) begin
                        pc_next      = pc_reg;
                        pm_addr_next = pc_reg + ADDR_W'(STEP_ONE);
                        state_next   = ST_SKIPCHK;
                    end
                end else if (op_is(w, M_6, P_CP) || is_cpc || is_cpi) begin
                    // flags only; the register file is not touched
                    status_flag_register_next[FLG_H:FLG_C] = cmp_flags;
                end else if (op_is(w, M_SKRB, P_SKRB)) begin
                    if (rd_v[f_bit(w)] == f_pol(w)) begin
                        pc_next      = pc_reg;
                        pm_addr_next = pc_reg + ADDR_W'(STEP_ONE);
                        state_next   = ST_SKIPCHK;
                    end
                end else if (op_is(w, M_SKIO, P_SKIO)) begin
                    io_addr_next = f_io(w);
                    io_rd_next   = 1'b1;
                    pc_next      = pc_reg;
                    state_next   = ST_IOWAIT;
                end else if (op_is(w, M_BRB, P_BRB)) begin
                    if (br_taken) begin
                        pc_next = br_target;
                    end
                end else if (op_is(w, M_6, P_MOV)) begin
                    we0 = 1'b1;
                    wi0 = f_rd(w);
                    wd0 = rr_v;
                end else if (op_is(w, M_8, P_COPY_REGISTER_PAIR)) begin
                    we0 = 1'b1;
                    wi0 = f_pair(w[7:4]);
                    wd0 = gpr[f_pair(w[3:0])];
                    we1 = 1'b1;
                    wi1 = f_pair(w[7:4]) | 5'h01;
                    wd1 = gpr[f_pair(w[3:0]) | 5'h01];
                end else if (op_is(w, M_4, P_LDI)) begin
                    we0 = 1'b1;
                    wi0 = f_rd_hi(w);
                    wd0 = f_imm(w);
                end else if (op_is(w, M_LD, P_LDS) || op_is(w, M_CALL, P_CALL)) begin
                    // second word carries the address
                    pc_next      = pc_reg;
                    pm_addr_next = pc_reg + ADDR_W'(STEP_ONE);
                    state_next   = ST_WORD2;
                end else if (op_is(w, M_LD, P_LD_X) || op_is(w, M_LD, P_LD_Y)) begin
                    ds_addr_next = ptr;
                    ds_rd_next   = 1'b1;
                    state_next   = ST_LOADWB;
                end else if (op_is(w, M_LD, P_LD_XP) || op_is(w, M_LD, P_LD_YP)) begin
                    ds_addr_next = ptr;
                    ds_rd_next   = 1'b1;
                    we0          = 1'b1;
                    wi0          = w[2] ? X_LO : Y_LO;
                    wd0          = 8'(ptr + 16'(STEP_ONE));
                    we1          = 1'b1;
                    wi1          = w[2] ? X_HI : Y_HI;
                    wd1          = 8'((ptr + 16'(STEP_ONE)) >> 8);
                    state_next   = ST_LOADWB;
                end else if (op_is(w, M_LD, P_LD_XM)) begin
                    // the read waits a cycle so it sees the decremented pointer
                    we0        = 1'b1;
                    wi0        = X_LO;
                    wd0        = 8'(xptr - 16'(STEP_ONE));
                    we1        = 1'b1;
                    wi1        = X_HI;
                    wd1        = 8'((xptr - 16'(STEP_ONE)) >> 8);
                    state_next = ST_PREDEC;
                end else if (op_is(w, M_ALL, P_RET) || op_is(w, M_ALL, P_INTERRUPT_EXIT)) begin
                    sp_next      = sp_reg + 16'(STEP_ONE);
                    ds_addr_next = sp_reg + 16'(STEP_ONE);
                    ds_rd_next   = 1'b1;
                    pc_next      = pc_reg;
                    state_next   = ST_POP_HI;
                end
                // anything else is outside this executor and just advances
            end

            ST_SKIPCHK: begin
                // skip distance depends on the length of the skipped instruction
                pc_next    = pc_reg + (is_two_word(w) ? ADDR_W'(STEP_THREE) : ADDR_W'(STEP_TWO));
                state_next = ST_FETCH;
            end

            ST_IOWAIT: begin
                if (io_rdata[f_bit(ir_reg)] == f_pol(ir_reg)) begin
                    pm_addr_next = pc_reg + ADDR_W'(STEP_ONE);
                    state_next   = ST_SKIPCHK;
                end else begin
                    pc_next    = pc_reg + ADDR_W'(STEP_ONE);
                    state_next = ST_FETCH;
                end
            end

            ST_WORD2: begin
                if (op_is(ir_reg, M_LD, P_LDS)) begin
                    ds_addr_next = w;
                    ds_rd_next   = 1'b1;
                    pc_next      = ret_addr;
                    state_next   = ST_LOADWB;
                end else begin
                    ds_addr_next  = sp_reg;
                    ds_wdata_next = ret_addr[7:0];
                    ds_we_next    = 1'b1;
                    sp_next       = sp_reg - 16'(STEP_ONE);
                    tmp_next      = w;
                    state_next    = ST_PUSH_HI;
                end
            end

            ST_PUSH_HI: begin
                ds_addr_next  = sp_reg;
                ds_wdata_next = 8'(16'(ret_addr) >> 8);
                ds_we_next    = 1'b1;
                sp_next       = sp_reg - 16'(STEP_ONE);
                pc_next       = ADDR_W'(tmp_reg);
                state_next    = ST_FETCH;
            end

            ST_PREDEC: begin
                ds_addr_next = xptr;
                ds_rd_next   = 1'b1;
                state_next   = ST_LOADWB;
            end

            ST_LOADWB: begin
                we0        = 1'b1;
                wi0        = f_rd(ir_reg);
                wd0        = ds_rdata;
                state_next = ST_FETCH;
            end

            ST_POP_HI: begin
                tmp_next     = {ds_rdata, 8'h00};
                sp_next      = sp_reg + 16'(STEP_ONE);
                ds_addr_next = sp_reg + 16'(STEP_ONE);
                ds_rd_next   = 1'b1;
                state_next   = ST_POP_LO;
            end

            ST_POP_LO: begin
                pc_next = ADDR_W'({tmp_reg[15:8], ds_rdata});
                if (op_is(ir_reg, M_ALL, P_INTERRUPT_EXIT)) begin
                    status_flag_register_next[FLG_I] = 1'b1;
                end
                state_next = ST_FETCH;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_FETCH;
            pc_reg    <= '0;
            sp_reg    <= SP_RESET;
            ir_reg    <= 16'h0000;
            tmp_reg   <= 16'h0000;
        end else if (ce) begin
            state_reg <= state_next;
            pc_reg    <= pc_next;
            sp_reg    <= sp_next;
            ir_reg    <= ir_next;
            tmp_reg   <= tmp_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_flag_register_reg <= STATUS_FLAG_REGISTER_RESET;
        end else if (ce) begin
            status_flag_register_reg <= status_flag_register_next;
        end
    end

    // no reset on the register file: software must load before use
    always_ff @(posedge clk) begin
        if (ce) begin
            if (we0) begin
                gpr[wi0] <= wd0;
            end
            if (we1) begin
                gpr[wi1] <= wd1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_addr_reg  <= '0;
            ds_addr_reg  <= 16'h0000;
            ds_wdata_reg <= 8'h00;
            ds_rd_reg    <= 1'b0;
            ds_we_reg    <= 1'b0;
            io_addr_reg  <= '0;
            io_rd_reg    <= 1'b0;
        end else if (ce) begin
            pm_addr_reg  <= pm_addr_next;
            ds_addr_reg  <= ds_addr_next;
            ds_wdata_reg <= ds_wdata_next;
            ds_rd_reg    <= ds_rd_next;
            ds_we_reg    <= ds_we_next;
            io_addr_reg  <= io_addr_next;
            io_rd_reg    <= io_rd_next;
        end
    end

    assign pm_addr  = pm_addr_reg;
    assign ds_addr  = ds_addr_reg;
    assign ds_wdata = ds_wdata_reg;
    assign ds_rd    = ds_rd_reg;
    assign ds_we    = ds_we_reg;
    assign io_addr  = io_addr_reg;
    assign io_rd    = io_rd_reg;
    assign pc       = pc_reg;
    assign status_flag_register     = status_flag_register_reg;

endmodule : bsl_core

/* File: hdl/bsl_pkg.sv */
// package: constants, opcode patterns and field decoders for the branch/skip/load executor
package bsl_pkg;

    localparam int ADDR_W_DEF = 16;
    localparam int NUM_REGS   = 32;
    localparam int IO_AW      = 5;

    localparam logic [15:0] SP_RESET_DEF = 16'h0FFF;

    localparam int STEP_ONE   = 1;
    localparam int STEP_TWO   = 2;
    localparam int STEP_THREE = 3;

    // status flag positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;
    localparam int FLG_I = 7;

    localparam logic [7:0] STATUS_FLAG_REGISTER_RESET = 8'h00;

    // pointer register numbers
    localparam logic [4:0] X_LO = 5'h1A;
    localparam logic [4:0] X_HI = 5'h1B;
    localparam logic [4:0] Y_LO = 5'h1C;
    localparam logic [4:0] Y_HI = 5'h1D;

    // opcode mask / pattern pairs
    localparam logic [15:0] M_6 = 16'hFC00;
    localparam logic [15:0] M_4 = 16'hF000;
    localparam logic [15:0] M_8 = 16'hFF00;
    localparam logic [15:0] M_BIT = 16'hFE08;
    localparam logic [15:0] M_LD = 16'hFE0F;
    localparam logic [15:0] M_CALL = 16'hFE0E;
    localparam logic [15:0] M_ALL = 16'hFFFF;
    localparam logic [15:0] P_COMPARE_SKIP_EQUAL = 16'h1000;
    localparam logic [15:0] P_CP = 16'h1400;
    localparam logic [15:0] P_CPC = 16'h0400;
    localparam logic [15:0] P_CPI = 16'h3000;
    localparam logic [15:0] P_MOV = 16'h2C00;
    localparam logic [15:0] P_COPY_REGISTER_PAIR = 16'h0100;
    localparam logic [15:0] P_LDI = 16'hE000;
    localparam logic [15:0] P_SKRB = 16'hFC00;
    localparam logic [15:0] M_SKRB = 16'hFC08;
    localparam logic [15:0] P_SKIO = 16'h9900;
    localparam logic [15:0] M_SKIO = 16'hFD00;
    localparam logic [15:0] P_BRB = 16'hF000;
    localparam logic [15:0] M_BRB = 16'hF800;
    localparam logic [15:0] P_LDS = 16'h9000;
    localparam logic [15:0] P_LD_X = 16'h900C;
    localparam logic [15:0] P_LD_XP = 16'h900D;
    localparam logic [15:0] P_LD_XM = 16'h900E;
    localparam logic [15:0] P_LD_YP = 16'h9009;
    localparam logic [15:0] P_LD_Y = 16'h8008;
    localparam logic [15:0] P_CALL = 16'h940E;
    localparam logic [15:0] P_RET = 16'h9508;
    localparam logic [15:0] P_INTERRUPT_EXIT = 16'h9518;
    localparam logic [15:0] M_TW_DS = 16'hFC0F;
    localparam logic [15:0] M_TW_JC = 16'hFE0C;
    localparam logic [15:0] P_TW_JC = 16'h940C;

    function automatic logic op_is(input logic [15:0] w, input logic [15:0] m, input logic [15:0] p);
        return (w & m) == p;
    endfunction : op_is

    function automatic logic [4:0] f_rd(input logic [15:0] w);
        return w[8:4];
    endfunction : f_rd

    function automatic logic [4:0] f_rr(input logic [15:0] w);
        return {w[9], w[3:0]};
    endfunction : f_rr

    function automatic logic [4:0] f_rd_hi(input logic [15:0] w);
        return {1'b1, w[7:4]};
    endfunction : f_rd_hi

    function automatic logic [7:0] f_imm(input logic [15:0] w);
        return {w[11:8], w[3:0]};
    endfunction : f_imm

    function automatic logic [2:0] f_bit(input logic [15:0] w);
        return w[2:0];
    endfunction : f_bit

    function automatic logic f_pol(input logic [15:0] w);
        return w[9];
    endfunction : f_pol

    function automatic logic [IO_AW-1:0] f_io(input logic [15:0] w);
        return w[7:3];
    endfunction : f_io

    function automatic logic [6:0] f_offs(input logic [15:0] w);
        return w[9:3];
    endfunction : f_offs

    function automatic logic [4:0] f_pair(input logic [3:0] n);
        return {n, 1'b0};
    endfunction : f_pair

    function automatic logic is_two_word(input logic [15:0] w);
        return op_is(w, M_TW_DS, P_LDS) || op_is(w, M_TW_JC, P_TW_JC);
    endfunction : is_two_word

endpackage : bsl_pkg

/* File: hdl/bsl_cmp.sv */
// compare unit: subtraction flags without a result write
module bsl_cmp
    import bsl_pkg::*;
(
    input  wire logic [7:0] op_a,
    input  wire logic [7:0] op_b,
    input  wire logic       use_carry,
    input  wire logic [7:0] status_flag_register,
    output logic      [5:0] flags
);
    logic [7:0] res;
    logic       cin;
    logic       c, z, n, v, h;

    always_comb begin
        cin = use_carry & status_flag_register[FLG_C];
        res = op_a - op_b - {7'h00, cin};
        h = (~op_a[3] & op_b[3]) | (op_b[3] & res[3]) | (res[3] & ~op_a[3]);
        c = (~op_a[7] & op_b[7]) | (op_b[7] & res[7]) | (res[7] & ~op_a[7]);
        v = (op_a[7] & ~op_b[7] & ~res[7]) | (~op_a[7] & op_b[7] & res[7]);
        n = res[7];
        // with borrow the zero flag only stays set across a multi-byte compare
        z = (res == 8'h00) & (~use_carry | status_flag_register[FLG_Z]);
        flags = {h, n ^ v, v, n, z, c};
    end
endmodule : bsl_cmp

/* File: hdl/bsl_branch.sv */
// branch unit: flag test and relative target
module bsl_branch
    import bsl_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF
)
(
    input  wire logic [7:0]        status_flag_register,
    input  wire logic [2:0]        sel,
    input  wire logic              want_set,
    input  wire logic [6:0]        offs,
    input  wire logic [ADDR_W-1:0] pc,
    output logic                   taken,
    output logic      [ADDR_W-1:0] target
);
    // every named flag branch is this generic test with a fixed flag number
    assign taken  = (status_flag_register[sel] == want_set);
    assign target = pc + ADDR_W'(STEP_ONE) + ADDR_W'($signed(offs));
endmodule : bsl_branch

/* File: test/bsl_mem_model.sv */
// memory model: program words, data space and io bytes facing the executor
module bsl_mem_model
    import bsl_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF
)
(
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] pm_addr,
    output logic      [15:0]       pm_rdata,
    input  wire logic [15:0]       ds_addr,
    input  wire logic              ds_rd,
    input  wire logic              ds_we,
    input  wire logic [7:0]        ds_wdata,
    output logic      [7:0]        ds_rdata,
    input  wire logic [IO_AW-1:0]  io_addr,
    input  wire logic              io_rd,
    output logic      [7:0]        io_rdata
);
    logic [15:0] pm [0:255];
    logic [7:0]  ds [0:4095];
    logic [7:0]  io [0:31];
    ////////////////////////////////////////////////////////////////////////
    // outside a read pulse the byte is inverted, so a late sample shows up
    assign pm_rdata = pm[pm_addr[7:0]];
    assign ds_rdata = ds_rd ? ds[ds_addr[11:0]] : ~ds[ds_addr[11:0]];
    assign io_rdata = io_rd ? io[io_addr] : ~io[io_addr];
    // plain always: the bench also preloads this array
    always @(posedge clk) begin
        if (ds_we) begin
            ds[ds_addr[11:0]] <= ds_wdata;
        end
    end
endmodule : bsl_mem_model

/* File: test/bsl_core_sva.sv */
// checker: timing relations on the executor's data and status ports
module bsl_core_sva
    import bsl_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF
)
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              ce,
    input wire logic [15:0]       ds_addr,
    input wire logic              ds_rd,
    input wire logic              ds_we,
    input wire logic              io_rd,
    input wire logic [ADDR_W-1:0] pc,
    input wire logic [7:0]        status_flag_register
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_strobe_excl: assert property (!(ds_rd && ds_we))
        else $error("data read and write strobes together");
    a_io_pulse_once: assert property (io_rd && ce |=> !io_rd)
        else $error("io read pulse longer than one cycle");
    a_hold_freezes: assert property (!ce |=> $stable(pc) && $stable(status_flag_register) && $stable(ds_addr))
        else $error("state moved while clock enable low");
    a_hold_keeps_pulse: assert property (!ce && ds_rd |=> ds_rd)
        else $error("read pulse lost while clock enable low");
    a_push_pair: assert property ($rose(ds_we) && ce |=> ds_we && ds_addr == $past(ds_addr) - 16'h0001)
        else $error("return address push not a descending pair");
    a_pop_ascend: assert property (ds_rd && $past(ds_rd) && $past(ce) |-> ds_addr == $past(ds_addr) + 16'h0001)
        else $error("return address pop not ascending");
    a_irq_flag_sticky: assert property (!$fell(status_flag_register[FLG_I]))
        else $error("interrupt flag cleared");
    a_reset_state: assert property (disable iff (1'b0) !rst_n |-> pc == '0 && status_flag_register == STATUS_FLAG_REGISTER_RESET)
        else $error("pc or flags not cleared in reset");
endmodule : bsl_core_sva

/* File: test/testbench.sv */
// testbench: runs short programs through the executor against a memory model
module testbench
    import bsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, ce, ds_rd, ds_we, io_rd;
    logic [15:0] pm_addr, pm_rdata, ds_addr, pc;
    logic [7:0]  ds_rdata, ds_wdata, io_rdata, status_flag_register;
    logic [4:0]  io_addr;
    int          err_count, check_count, cycles;
    ////////////////////////////////////////////////////////////////////////
    bsl_core u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .ds_addr(ds_addr), .ds_rdata(ds_rdata), .ds_rd(ds_rd), .ds_we(ds_we), .ds_wdata(ds_wdata),
        .io_addr(io_addr), .io_rdata(io_rdata), .io_rd(io_rd), .pc(pc), .status_flag_register(status_flag_register));
    bsl_mem_model u_mem (.clk(clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .ds_addr(ds_addr),
        .ds_rd(ds_rd), .ds_we(ds_we), .ds_wdata(ds_wdata), .ds_rdata(ds_rdata), .io_addr(io_addr),
        .io_rd(io_rd), .io_rdata(io_rdata));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // program words beyond the list are a branch-to-self on a clear interrupt flag
    task automatic run(input logic [15:0] prog[$], input logic [15:0] stop);
        int i;
        rst_n <= 1'b0;
        foreach (u_mem.pm[j]) u_mem.pm[j] = 16'hF7FF;
        foreach (prog[j]) u_mem.pm[j] = prog[j];
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // clock enable dropped now and then so the freeze path is exercised too
        for (i = 0; i < 300 && pc !== stop; i++) begin
            @(posedge clk);
            ce <= (i % 5 != 3);
        end
        ce <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : run
    task automatic t_cmp_branch();
        run('{16'hE005, 16'hE015, 16'h1701, 16'hF011, 16'hF7FF, 16'hF7FF, 16'hF411}, 16'h0007);
        check(pc, 16'h0007);
        check(pm_addr, 16'h0007);
        check({8'h00, status_flag_register}, 16'h0002);
    endtask : t_cmp_branch
    task automatic t_skips();
        run('{16'hE800, 16'hE810, 16'h1301, 16'h9100, 16'h0100, 16'hFF07, 16'hF7FF, 16'hFD07}, 16'h0008);
        check(pc, 16'h0008);
        check({8'h00, status_flag_register}, 16'h0000);
    endtask : t_skips
    task automatic t_io_loads();
        u_mem.io[3] = 8'h04;
        u_mem.ds[12'h110] = 8'h33;
        u_mem.ds[12'h111] = 8'h44;
        run('{16'h9B1A, 16'hF7FF, 16'h991A, 16'hE1A0, 16'hE0B1, 16'h910D, 16'h911D, 16'h912E,
              16'h9130, 16'h0110, 16'h1721, 16'h1303}, 16'h000D);
        check(pc, 16'h000D);
        check({8'h00, status_flag_register}, 16'h0002);
        check(ds_addr, 16'h0110);
        check({11'h000, io_addr}, 16'h0003);
    endtask : t_io_loads
    task automatic t_call_signed();
        run('{16'h940E, 16'h000C, 16'hF00F, 16'hF7FF, 16'hE800, 16'hE011, 16'h1701, 16'hF00C,
              16'hF7FF, 16'hF00B, 16'hF7FF, 16'hF3FF, 16'h9518}, 16'h000B);
        check(pc, 16'h000B);
        check({8'h00, status_flag_register}, 16'h00B8);
        check({8'h00, u_mem.ds[12'hFFF]}, 16'h0002);
        check({8'h00, u_mem.ds[12'hFFE]}, 16'h0000);
    endtask : t_call_signed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        err_count = 0;
        check_count = 0;
        cycles = 0;
        repeat (20) @(posedge clk);
        t_cmp_branch();
        t_skips();
        t_io_loads();
        t_call_signed();
        finish_test();
    end
endmodule : testbench

bind bsl_core bsl_core_sva #(.ADDR_W(ADDR_W)) u_sva (.clk(clk), .rst_n(rst_n), .ce(ce), .ds_addr(ds_addr),
    .ds_rd(ds_rd), .ds_we(ds_we), .io_rd(io_rd), .pc(pc), .status_flag_register(status_flag_register));
